// >>> shared/irqv_params.svh
// constants for the interrupt vector and reach event command block
// included by the package users; no logic here
`ifndef IRQV_PARAMS_SVH
`define IRQV_PARAMS_SVH
`define IRQV_OP_DEFINE_HANDLER 8'h25
`define IRQV_OP_HANDLER_RETURN 8'h26
`define IRQV_OP_IRQ_ENABLE     8'h19
`define IRQV_OP_IRQ_DISABLE    8'h1A
`define IRQV_OP_MOVE_TO_POS    8'h04
`define IRQV_OP_USER_FIRST     8'h40
`define IRQV_OP_USER_LAST      8'h47
`define IRQV_OP_REACH_REQ      8'h8A
`define IRQV_ST_OK             8'h64
`define IRQV_ST_REACHED        8'h80
`define IRQV_ST_BAD_CMD        8'h02
`define IRQV_ST_BAD_TYPE       8'h03
`define IRQV_IRQ_GLOBAL        8'hFF
`define IRQV_REACH_ONCE        8'h00
`define IRQV_REACH_ALWAYS      8'h01
`define IRQV_MOTOR_MASK_W      4
`endif

// >>> shared/irqv_pkg.sv
// types for the interrupt vector and reach event command block
// used with package scope, never imported
package irqv_pkg;
  typedef enum logic [3:0] {
    IRQV_IDLE   = 4'b0001,
    IRQV_DECODE = 4'b0010,
    IRQV_ENTER  = 4'b0100,
    IRQV_RETURN = 4'b1000
  } irqv_state_t;
endpackage : irqv_pkg

// >>> hdl/irqv_vector_table.sv
// handler address table, one entry per interrupt number
// assumes single clock, synchronous active-low reset; registered read
`timescale 1ns/1ps
module irqv_vector_table #(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 16
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : irqv_vector_table

// >>> hdl/irqv_cmd.sv
// interpreter slice: handler vectors, handler return, user functions, reach event
// assumes decoded command frames arrive as a one-cycle strobe with fields on mclk;
// reply framing and checksum are added downstream
`timescale 1ns/1ps
`include "irqv_params.svh"
module irqv_cmd #(
  parameter int VEC_ADDR_W = 5,
  parameter int PC_W       = 16,
  parameter int IRQ_N      = 32
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // decoded command
  input  wire logic              cmd_valid,
  input  wire logic              cmd_from_host,
  input  wire logic [7:0]        cmd_opcode,
  input  wire logic [7:0]        cmd_type,
  input  wire logic [7:0]        cmd_bank,
  input  wire logic [31:0]       cmd_value,
  // user function result
  input  wire logic [31:0]       user_value,
  // interpreter context
  input  wire logic [31:0]       accu_in,
  input  wire logic [31:0]       xreg_in,
  input  wire logic [7:0]        flags_in,
  input  wire logic [PC_W-1:0]   pc_in,
  output logic      [31:0]       accu_out,
  output logic      [31:0]       xreg_out,
  output logic      [7:0]        flags_out,
  output logic      [PC_W-1:0]   pc_out,
  output logic                   ctx_load,
  // interrupt sources and motion
  input  wire logic [IRQ_N-1:0]  irq_pend,
  input  wire logic              target_reached,
  output logic                   irq_taken,
  output logic      [VEC_ADDR_W-1:0] irq_taken_num,
  output logic                   in_handler,
  output logic                   irq_global_en,
  // reply
  output logic                   reply_valid,
  output logic      [7:0]        reply_status,
  output logic      [7:0]        reply_command,
  output logic      [31:0]       reply_value
);
  ////////////////////////////////////////////////////////////////////////////////
  irqv_pkg::irqv_state_t state;
  logic [PC_W-1:0]       vec_rd_data;
  logic [VEC_ADDR_W-1:0] vec_rd_addr;
  logic                  vec_wr;
  logic [IRQ_N-1:0]      irq_en;
  logic [31:0]           sv_accu;
  logic [31:0]           sv_xreg;
  logic [7:0]            sv_flags;
  logic [PC_W-1:0]       sv_pc;
  logic                  reach_armed;
  logic                  reach_sticky;
  logic                  reach_moving;
  logic [`IRQV_MOTOR_MASK_W-1:0] reach_mask;
  logic                  irq_req;
  logic [VEC_ADDR_W-1:0] irq_sel;
  logic                  is_user;
  logic                  reach_fire;

  assign is_user = (cmd_opcode >= `IRQV_OP_USER_FIRST) && (cmd_opcode <= `IRQV_OP_USER_LAST);
  assign vec_wr  = cmd_valid && (cmd_opcode == `IRQV_OP_DEFINE_HANDLER)
                   && (cmd_type < 8'(IRQ_N));
  assign reach_fire = reach_moving && target_reached;

  // lowest pending enabled interrupt wins
  always_comb
  begin
    irq_req = 1'b0;
    irq_sel = '0;
    for (int i = IRQ_N - 1; i >= 0; i--)
    begin
      if (irq_pend[i] && irq_en[i])
      begin
        irq_req = 1'b1;
        irq_sel = VEC_ADDR_W'(i);
      end
    end
  end

  // number latched at entry, so a request that appears later cannot swap the vector
  assign vec_rd_addr = irq_taken_num;

  irqv_vector_table #(
    .ADDR_W (VEC_ADDR_W),
    .DATA_W (PC_W)
  ) u_table (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (vec_wr),
    .wr_addr (cmd_type[VEC_ADDR_W-1:0]),
    .wr_data (cmd_value[PC_W-1:0]),
    .rd_addr (vec_rd_addr),
    .rd_data (vec_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // enable bits; number 255 is the global switch
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      irq_en        <= '0;
      irq_global_en <= 1'b0;
    end
    else if (cmd_valid && (cmd_opcode == `IRQV_OP_IRQ_ENABLE
                           || cmd_opcode == `IRQV_OP_IRQ_DISABLE))
    begin
      if (cmd_type == `IRQV_IRQ_GLOBAL)
      begin
        irq_global_en <= (cmd_opcode == `IRQV_OP_IRQ_ENABLE);
      end
      else if (cmd_type < 8'(IRQ_N))
      begin
        irq_en[cmd_type[VEC_ADDR_W-1:0]] <= (cmd_opcode == `IRQV_OP_IRQ_ENABLE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // entry and return; no nesting, a handler is not interrupted
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state         <= irqv_pkg::IRQV_IDLE;
      in_handler    <= 1'b0;
      irq_taken     <= 1'b0;
      irq_taken_num <= '0;
      ctx_load      <= 1'b0;
      pc_out        <= '0;
      accu_out      <= '0;
      xreg_out      <= '0;
      flags_out     <= '0;
      sv_accu       <= '0;
      sv_xreg       <= '0;
      sv_flags      <= '0;
      sv_pc         <= '0;
    end
    else
    begin
      irq_taken <= 1'b0;
      ctx_load  <= 1'b0;
      case (state)
        irqv_pkg::IRQV_IDLE:
        begin
          if (cmd_valid && cmd_opcode == `IRQV_OP_HANDLER_RETURN && in_handler
              && !cmd_from_host)
          begin
            state <= irqv_pkg::IRQV_RETURN;
          end
          else if (irq_req && irq_global_en && !in_handler && !cmd_valid)
          begin
            sv_accu       <= accu_in;
            sv_xreg       <= xreg_in;
            sv_flags      <= flags_in;
            sv_pc         <= pc_in;
            irq_taken_num <= irq_sel;
            state         <= irqv_pkg::IRQV_DECODE;
          end
        end
        irqv_pkg::IRQV_DECODE:
        begin
          // table read data is one cycle late
          state <= irqv_pkg::IRQV_ENTER;
        end
        irqv_pkg::IRQV_ENTER:
        begin
          pc_out     <= vec_rd_data;
          accu_out   <= sv_accu;
          xreg_out   <= sv_xreg;
          flags_out  <= sv_flags;
          ctx_load   <= 1'b1;
          irq_taken  <= 1'b1;
          in_handler <= 1'b1;
          state      <= irqv_pkg::IRQV_IDLE;
        end
        irqv_pkg::IRQV_RETURN:
        begin
          accu_out   <= sv_accu;
          xreg_out   <= sv_xreg;
          flags_out  <= sv_flags;
          pc_out     <= sv_pc;
          ctx_load   <= 1'b1;
          in_handler <= 1'b0;
          state      <= irqv_pkg::IRQV_IDLE;
        end
        default:
        begin
          state <= irqv_pkg::IRQV_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reach event arming; a move command starts the watch
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      reach_armed  <= 1'b0;
      reach_sticky <= 1'b0;
      reach_moving <= 1'b0;
      reach_mask   <= '0;
    end
    else
    begin
      if (reach_fire)
      begin
        reach_moving <= 1'b0;
      end
      if (cmd_valid && cmd_opcode == `IRQV_OP_REACH_REQ && cmd_from_host
          && cmd_type <= `IRQV_REACH_ALWAYS)
      begin
        reach_armed  <= 1'b1;
        reach_sticky <= (cmd_type == `IRQV_REACH_ALWAYS);
        reach_mask   <= cmd_value[`IRQV_MOTOR_MASK_W-1:0];
      end
      else if (cmd_valid && cmd_opcode == `IRQV_OP_MOVE_TO_POS && reach_armed)
      begin
        reach_moving <= 1'b1;
        reach_armed  <= reach_sticky;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // replies; the immediate reply has priority, a reached reply in the same cycle is dropped
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      reply_valid   <= 1'b0;
      reply_status  <= 8'h00;
      reply_command <= 8'h00;
      reply_value   <= 32'h00000000;
    end
    else
    begin
      reply_valid <= 1'b0;
      if (cmd_valid && cmd_opcode == `IRQV_OP_REACH_REQ)
      begin
        reply_valid   <= 1'b1;
        reply_command <= `IRQV_OP_REACH_REQ;
        reply_value   <= {24'h000000, cmd_value[7:0]};
        if (!cmd_from_host)
        begin
          reply_status <= `IRQV_ST_BAD_CMD;
        end
        else if (cmd_type > `IRQV_REACH_ALWAYS)
        begin
          reply_status <= `IRQV_ST_BAD_TYPE;
        end
        else
        begin
          reply_status <= `IRQV_ST_OK;
        end
      end
      else if (cmd_valid && (vec_wr || cmd_opcode == `IRQV_OP_HANDLER_RETURN))
      begin
        reply_valid   <= 1'b1;
        reply_status  <= `IRQV_ST_OK;
        reply_command <= cmd_opcode;
        reply_value   <= 32'h00000000;
      end
      else if (cmd_valid && is_user)
      begin
        reply_valid   <= 1'b1;
        reply_status  <= `IRQV_ST_OK;
        reply_command <= cmd_opcode;
        reply_value   <= user_value;
      end
      else if (reach_fire)
      begin
        reply_valid   <= 1'b1;
        reply_status  <= `IRQV_ST_REACHED;
        reply_command <= `IRQV_OP_REACH_REQ;
        reply_value   <= {28'h0000000, reach_mask};
      end
    end
  end
endmodule : irqv_cmd

// >>> test/irqv_cmd_sva.sv
// checker for irqv_cmd: reply codes, context moves, global enable
// bound to irqv_cmd; one clock mclk, sync reset rst_n
`timescale 1ns/1ps
module irqv_cmd_sva (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // command
  input wire logic        cmd_valid,
  input wire logic        cmd_from_host,
  input wire logic [7:0]  cmd_opcode,
  input wire logic [7:0]  cmd_type,
  input wire logic [31:0] cmd_value,
  input wire logic [31:0] user_value,
  // context
  input wire logic        ctx_load,
  input wire logic        irq_taken,
  input wire logic        in_handler,
  input wire logic        irq_global_en,
  // reply
  input wire logic        reply_valid,
  input wire logic [7:0]  reply_status,
  input wire logic [7:0]  reply_command,
  input wire logic [31:0] reply_value
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_ok;
    reply_valid && reply_status == 8'h64;
  endsequence
  sequence s_restore;
    ctx_load ##1 !in_handler;
  endsequence
  property p_define_handler_cmd;
    cmd_valid && cmd_opcode == 8'h25 && cmd_type < 8'h20 |=> s_ok;
  endproperty
  a_define_handler_cmd: assert property (p_define_handler_cmd) else $error("vector define not answered");
  property p_user;
    cmd_valid && cmd_opcode[7:3] == 5'h08 |=> s_ok ##0 reply_value == $past(user_value);
  endproperty
  a_user: assert property (p_user) else $error("user function reply wrong");
  property p_ack;
    cmd_valid && cmd_from_host && cmd_opcode == 8'h8A && cmd_type < 8'h02
      |=> s_ok ##0 reply_command == 8'h8A
          && reply_value == {24'h000000, $past(cmd_value[7:0])};
  endproperty
  a_ack: assert property (p_ack) else $error("reach request reply wrong");
  property p_prog;
    cmd_valid && !cmd_from_host && cmd_opcode == 8'h8A |=> reply_valid && reply_status == 8'h02;
  endproperty
  a_prog: assert property (p_prog) else $error("program reach request taken");
  property p_reached;
    reply_valid && reply_status == 8'h80 |-> reply_command == 8'h8A && reply_value == 32'h1;
  endproperty
  a_reached: assert property (p_reached) else $error("reached reply wrong");
  property p_ret;
    cmd_valid && !cmd_from_host && cmd_opcode == 8'h26 && in_handler |=> s_ok ##1 s_restore;
  endproperty
  a_ret: assert property (p_ret) else $error("handler return did not restore");
  property p_entry;
    irq_taken |-> ctx_load ##1 in_handler;
  endproperty
  a_entry: assert property (p_entry) else $error("entry without context load");
  property p_glob;
    cmd_valid && cmd_type == 8'hFF && (cmd_opcode == 8'h19 || cmd_opcode == 8'h1A)
      |=> irq_global_en == ($past(cmd_opcode) == 8'h19);
  endproperty
  a_glob: assert property (p_glob) else $error("global enable wrong");
endmodule : irqv_cmd_sva
bind irqv_cmd irqv_cmd_sva irqv_cmd_sva_i (.*);

// >>> test/irqv_host_model.sv
// host side model: sends decoded command strobes
// drives at the falling edge of mclk; the block samples at the rising one
`timescale 1ns/1ps
module irqv_host_model (
  // clock
  input wire logic mclk,
  // command
  output logic        cmd_valid,
  output logic        cmd_from_host,
  output logic [7:0]  cmd_opcode,
  output logic [7:0]  cmd_type,
  output logic [7:0]  cmd_bank,
  output logic [31:0] cmd_value
);
  initial
  begin
    {cmd_valid, cmd_from_host, cmd_opcode, cmd_type, cmd_bank, cmd_value} = '0;
  end
  task automatic send(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val,
                      input logic host);
    @(negedge mclk);
    {cmd_valid, cmd_from_host, cmd_opcode, cmd_type, cmd_bank, cmd_value} =
      {1'b1, host, op, typ, 8'h00, val};
    @(negedge mclk);
    // stale fields except cmd_from_host inverted so nothing leans on them
    {cmd_valid, cmd_opcode, cmd_type, cmd_bank, cmd_value} = {1'b0, ~op, ~typ, 8'hFF, ~val};
  endtask : send
endmodule : irqv_host_model

// >>> test/tb.sv
// self-checking bench for irqv_cmd with the host model
// clock 50 ns, sync reset held 16 cycles, inputs driven at falling edge
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [7:0] op, typ; logic host; logic [31:0] val; logic [7:0] st;}
    irqv_row_t;
  logic        mclk, rst_n, target_reached;
  logic [31:0] user_value, accu_in, xreg_in, irq_pend;
  logic [7:0]  flags_in;
  logic [15:0] pc_in;
  wire logic   cmd_valid, cmd_from_host, ctx_load, irq_taken, in_handler, irq_global_en;
  wire logic   reply_valid;
  wire logic [7:0]  cmd_opcode, cmd_type, cmd_bank, flags_out, reply_status, reply_command;
  wire logic [31:0] cmd_value, accu_out, xreg_out, reply_value;
  wire logic [15:0] pc_out;
  wire logic [4:0]  irq_taken_num;
  int error_cnt, cmp_count, cyc, n;
  irqv_row_t rows [8] = '{
    '{8'h25, 8'h03, 1'b0, 32'h32, 8'h64}, '{8'h25, 8'h20, 1'b0, 32'h32, 8'h00},
    '{8'h8A, 8'h00, 1'b0, 32'h01, 8'h02}, '{8'h8A, 8'h02, 1'b1, 32'h01, 8'h03},
    // enable and disable are answered outside this block
    '{8'h19, 8'h03, 1'b0, 32'h00, 8'h00}, '{8'h19, 8'hFF, 1'b0, 32'h00, 8'h00},
    '{8'h1A, 8'hFF, 1'b1, 32'h00, 8'h00}, '{8'h19, 8'hFF, 1'b1, 32'h00, 8'h00}};
  irqv_cmd irqv_cmd_i (.*);
  irqv_host_model irqv_host_model_i (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // status 00 means no reply may come
  task automatic get_reply(input logic [7:0] st);
    n = 0;
    while (reply_valid !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    chk("reply status", {24'h0, st}, reply_valid === 1'b1 ? {24'h0, reply_status} : 32'h0);
  endtask : get_reply
  task automatic move_and_reach(input logic [7:0] st);
    irqv_host_model_i.send(8'h04, 8'h00, 32'h0, 1'b1);
    @(negedge mclk);
    target_reached = 1'b1;
    @(negedge mclk);
    target_reached = 1'b0;
    get_reply(st);
  endtask : move_and_reach
  task automatic test_done;
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    {rst_n, target_reached, irq_pend, user_value} = '0;
    xreg_in = 32'h000000B2;
    flags_in = 8'hC3;
    accu_in = 32'hA1;
    pc_in = 16'h0010;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    chk("idle handler", 32'h0, {31'h0, in_handler});
    foreach (rows[i])
    begin
      irqv_host_model_i.send(rows[i].op, rows[i].typ, rows[i].val, rows[i].host);
      get_reply(rows[i].st);
    end
    chk("global enable", 32'h1, {31'h0, irq_global_en});
    for (int i = 0; i < 8; i++)
    begin
      user_value = 32'h5A000000 + i;
      irqv_host_model_i.send(8'h40 + i[7:0], 8'h00, 32'h0, 1'b1);
      get_reply(8'h64);
      chk("user value", user_value, reply_value);
    end
    // host sends mask 1 only
    irqv_host_model_i.send(8'h8A, 8'h01, 32'h1, 1'b1);
    get_reply(8'h64);
    chk("reach command", 32'h8A, {24'h0, reply_command});
    chk("reach value", 32'h1, reply_value);
    repeat (2) move_and_reach(8'h80);
    irqv_host_model_i.send(8'h8A, 8'h00, 32'h1, 1'b1);
    get_reply(8'h64);
    move_and_reach(8'h80);
    move_and_reach(8'h00);
    @(negedge mclk);
    irq_pend[3] = 1'b1;
    n = 0;
    while (irq_taken !== 1'b1 && n < 8)
    begin
      @(negedge mclk);
      n++;
    end
    irq_pend = '0;
    chk("handler address", 32'h32, {16'h0, pc_out});
    chk("irq number", 32'h3, {27'h0, irq_taken_num});
    chk("in handler", 32'h1, {31'h0, in_handler});
    accu_in = 32'h0;
    xreg_in = 32'h0;
    flags_in = 8'h00;
    pc_in = 16'h0077;
    // handler body ends with its return
    irqv_host_model_i.send(8'h26, 8'hFF, 32'h0, 1'b0);
    get_reply(8'h64);
    n = 0;
    while (ctx_load !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    chk("restored accu", 32'hA1, accu_out);
    chk("restored pc", 32'h10, {16'h0, pc_out});
    chk("restored xreg", 32'hB2, xreg_out);
    chk("restored flags", 32'hC3, {24'h0, flags_out});
    chk("handler left", 32'h0, {31'h0, in_handler});
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    chk("global after reset", 32'h0, {31'h0, irq_global_en});
    test_done();
  end
endmodule : tb
